/* verilog/omd_defines.vh */
// Constants for the operand mode decoder: instruction fields, encodings, APB map.
// Assumes a 32-bit instruction word and a 32-bit APB with byte addresses.
//
// Overview of operation
// RL1 - Three-operand: first source register, literal or special register from its two bits.
// RL2 - Three-operand: second source register, literal or special register from its two bits.
// RL3 - Three-operand: src/dst bit 0 register; 1 literal if read, special if written.
// RL4 - Producers never set src/dst mode bit for write-only or read-modify-write operands.
// RL5 - Compare-branch, both bits 0: all three operands are registers.
// RL6 - Compare-branch, mode bit 1, special bit 0: first source literal, others registers.
// RL7 - Compare-branch, special bit 1: second source and destination special registers.
// RL8 - Compare-branch and branch-only: guess flag 0 predicts true, 1 predicts false.
// RL9 - Producers never emit both mode and special bits set for one source.
// RL10 - Reserved operand-mode combinations raise an invalid-opcode fault instead of executing.
`ifndef OMD_DEFINES_VH
`define OMD_DEFINES_VH

// Instruction fields
`define OMD_OPC_HI        31
`define OMD_OPC_LO        24
`define OMD_REG_SRCDST_M  13
`define OMD_REG_SRC2_M    12
`define OMD_REG_SRC1_M    11
`define OMD_REG_SRC2_S    6
`define OMD_REG_SRC1_S    5
`define OMD_CB_SRC1_M     13
`define OMD_CB_SRC2_S     0
`define OMD_BR_GUESS      1

// Opcode ranges of each format
`define OMD_CTRL_OPC_HI   8'h1f
`define OMD_CB_OPC_LO     8'h20
`define OMD_CB_OPC_HI     8'h3f
`define OMD_REG_OPC_LO    8'h58
`define OMD_REG_OPC_HI    8'h7f

// Operand source encodings
`define OMD_SEL_REG       2'h0
`define OMD_SEL_LIT       2'h1
`define OMD_SEL_SFR       2'h2
`define OMD_SEL_NONE      2'h3

// Format encodings
`define OMD_FMT_NONE      2'h0
`define OMD_FMT_REG       2'h1
`define OMD_FMT_CB        2'h2
`define OMD_FMT_CTRL      2'h3

// APB map
`define OMD_AW            12
`define OMD_ADDR_CTRL     12'h000
`define OMD_ADDR_STATUS   12'h004
`define OMD_ADDR_FCNT     12'h008
`define OMD_CTRL_RESET    32'h0000_0001
`define OMD_CTRL_FAULT_EN 0
`define OMD_ST_SRC1       0
`define OMD_ST_SRC2       2
`define OMD_ST_SDS        4
`define OMD_ST_SDD        6
`define OMD_ST_FMT        8
`define OMD_ST_GUESS      10
`define OMD_ST_FAULT      11
`define OMD_FCNT_W        16

`endif

/* verilog/omd_operand_sel.v */
// One source operand select from its mode bit and special-function bit.
// Assumes both bits come from the same instruction word, same clock.
`timescale 1ns/10ps
`include "omd_defines.vh"

module omd_operand_sel (
    input  wire       mode_bit_in,
    input  wire       sfr_bit_in,
    output reg  [1:0] sel_out,
    output wire       reserved_out
);
    assign reserved_out = mode_bit_in & sfr_bit_in; // RL10

    always @* begin
        case ({mode_bit_in, sfr_bit_in})
            2'b00:   sel_out = `OMD_SEL_REG;
            2'b10:   sel_out = `OMD_SEL_LIT;
            2'b01:   sel_out = `OMD_SEL_SFR;
            default: sel_out = `OMD_SEL_NONE;
        endcase
    end
endmodule // omd_operand_sel

/* verilog/omd_decoder.v */
// Operand mode decoder top: decodes one instruction word per cycle.
// Assumes instruction and APB signals are synchronous to CLK_IN.
`timescale 1ns/10ps
`include "omd_defines.vh"

module omd_decoder (
    input  wire                CLK_IN,
    input  wire                RESETN_IN,
    input  wire [31:0]         INSTR_IN,
    input  wire                INSTR_VALID_IN,
    input  wire                SRCDST_WRITTEN_IN,
    input  wire                PSEL_IN,
    input  wire                PENABLE_IN,
    input  wire                PWRITE_IN,
    input  wire [`OMD_AW-1:0]  PADDR_IN,
    input  wire [31:0]         PWDATA_IN,
    output reg  [31:0]         PRDATA_OUT,
    output reg                 PREADY_OUT,
    output reg                 PSLVERR_OUT,
    output reg                 DEC_VALID_OUT,
    output reg  [1:0]          FORMAT_OUT,
    output reg  [1:0]          SRC1_SEL_OUT,
    output reg  [1:0]          SRC2_SEL_OUT,
    output reg  [1:0]          SRCDST_SRC_SEL_OUT,
    output reg  [1:0]          SRCDST_DST_SEL_OUT,
    output reg                 HAS_GUESS_OUT,
    output reg                 GUESS_FALSE_OUT,
    output reg                 INVALID_OPCODE_OUT
);
    // Field extraction
    wire [7:0] opcode;
    wire       is_ctrl;
    wire       is_cb;
    wire       is_reg;
    wire [1:0] reg_src1_sel;
    wire [1:0] reg_src2_sel;
    wire       reg_src1_rsv;
    wire       reg_src2_rsv;
    wire       srcdst_mode_bit;
    wire       cb_src1_mode_bit;
    wire       cb_src2_sfr_bit;
    wire       guess_flag;

    assign opcode           = INSTR_IN[`OMD_OPC_HI:`OMD_OPC_LO];
    assign is_ctrl          = (opcode <= `OMD_CTRL_OPC_HI);
    assign is_cb            = (opcode >= `OMD_CB_OPC_LO) && (opcode <= `OMD_CB_OPC_HI);
    assign is_reg           = (opcode >= `OMD_REG_OPC_LO) && (opcode <= `OMD_REG_OPC_HI);
    assign srcdst_mode_bit  = INSTR_IN[`OMD_REG_SRCDST_M];
    assign cb_src1_mode_bit = INSTR_IN[`OMD_CB_SRC1_M];
    assign cb_src2_sfr_bit  = INSTR_IN[`OMD_CB_SRC2_S];
    assign guess_flag       = INSTR_IN[`OMD_BR_GUESS];

    omd_operand_sel u_src1_sel (
        .mode_bit_in  (INSTR_IN[`OMD_REG_SRC1_M]),
        .sfr_bit_in   (INSTR_IN[`OMD_REG_SRC1_S]),
        .sel_out      (reg_src1_sel),
        .reserved_out (reg_src1_rsv)
    ); // RL1

    omd_operand_sel u_src2_sel (
        .mode_bit_in  (INSTR_IN[`OMD_REG_SRC2_M]),
        .sfr_bit_in   (INSTR_IN[`OMD_REG_SRC2_S]),
        .sel_out      (reg_src2_sel),
        .reserved_out (reg_src2_rsv)
    ); // RL2

    // Control and status registers
    reg [31:0]             ctrl_q;
    reg                    fault_seen_q;
    reg [`OMD_FCNT_W-1:0]  fault_cnt_q;
    wire                   fault_en;
    assign fault_en = ctrl_q[`OMD_CTRL_FAULT_EN];

    // Combinational decode
    reg [1:0] fmt_d;
    reg [1:0] src1_d;
    reg [1:0] src2_d;
    reg [1:0] sds_d;
    reg [1:0] sdd_d;
    reg       has_guess_d;
    reg       guess_false_d;
    reg       rsv_d;

    always @* begin
        fmt_d         = `OMD_FMT_NONE;
        src1_d        = `OMD_SEL_NONE;
        src2_d        = `OMD_SEL_NONE;
        sds_d         = `OMD_SEL_NONE;
        sdd_d         = `OMD_SEL_NONE;
        has_guess_d   = 1'b0;
        guess_false_d = 1'b0;
        rsv_d         = 1'b0;
        if (is_reg) begin
            fmt_d  = `OMD_FMT_REG;
            src1_d = reg_src1_sel; // RL1
            src2_d = reg_src2_sel; // RL2
            if (srcdst_mode_bit) begin
                sds_d = `OMD_SEL_LIT; // RL3
                sdd_d = `OMD_SEL_SFR; // RL3
            end else begin
                sds_d = `OMD_SEL_REG; // RL3
                sdd_d = `OMD_SEL_REG; // RL3
            end
            // Source/dst literal cannot be a write target
            rsv_d = reg_src1_rsv | reg_src2_rsv |
                    (srcdst_mode_bit & SRCDST_WRITTEN_IN); // RL10 RL4 RL9
        end else if (is_cb) begin
            fmt_d         = `OMD_FMT_CB;
            has_guess_d   = 1'b1;
            guess_false_d = guess_flag; // RL8
            if (cb_src1_mode_bit) begin
                src1_d = `OMD_SEL_LIT; // RL6
            end else begin
                src1_d = `OMD_SEL_REG; // RL5
            end
            if (cb_src2_sfr_bit) begin
                src2_d = `OMD_SEL_SFR; // RL7
                sdd_d  = `OMD_SEL_SFR; // RL7
            end else begin
                src2_d = `OMD_SEL_REG; // RL5
                sdd_d  = `OMD_SEL_REG; // RL6
            end
        end else if (is_ctrl) begin
            fmt_d         = `OMD_FMT_CTRL;
            has_guess_d   = 1'b1;
            guess_false_d = guess_flag; // RL8
        end
    end

    wire fault_evt;
    assign fault_evt = INSTR_VALID_IN & rsv_d & fault_en;

    // Registered decode outputs
    always @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            DEC_VALID_OUT      <= 1'b0;
            FORMAT_OUT         <= `OMD_FMT_NONE;
            SRC1_SEL_OUT       <= `OMD_SEL_NONE;
            SRC2_SEL_OUT       <= `OMD_SEL_NONE;
            SRCDST_SRC_SEL_OUT <= `OMD_SEL_NONE;
            SRCDST_DST_SEL_OUT <= `OMD_SEL_NONE;
            HAS_GUESS_OUT      <= 1'b0;
            GUESS_FALSE_OUT    <= 1'b0;
            INVALID_OPCODE_OUT <= 1'b0;
        end else begin
            DEC_VALID_OUT      <= INSTR_VALID_IN;
            INVALID_OPCODE_OUT <= fault_evt; // RL10
            if (INSTR_VALID_IN) begin
                FORMAT_OUT         <= fmt_d;
                SRC1_SEL_OUT       <= src1_d;
                SRC2_SEL_OUT       <= src2_d;
                SRCDST_SRC_SEL_OUT <= sds_d;
                SRCDST_DST_SEL_OUT <= sdd_d;
                HAS_GUESS_OUT      <= has_guess_d;
                GUESS_FALSE_OUT    <= guess_false_d;
            end
        end
    end

    // APB slave, one wait state
    wire apb_access;
    wire apb_done;
    wire apb_wr;
    wire addr_ok;
    assign apb_access = PSEL_IN & PENABLE_IN;
    assign apb_done   = apb_access & PREADY_OUT;
    assign apb_wr     = apb_done & PWRITE_IN;
    assign addr_ok    = (PADDR_IN == `OMD_ADDR_CTRL) || (PADDR_IN == `OMD_ADDR_STATUS) ||
                        (PADDR_IN == `OMD_ADDR_FCNT);

    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        case (PADDR_IN)
            `OMD_ADDR_CTRL: begin
                rdata_d = ctrl_q;
            end
            `OMD_ADDR_STATUS: begin
                rdata_d[`OMD_ST_SRC1+1:`OMD_ST_SRC1] = SRC1_SEL_OUT;
                rdata_d[`OMD_ST_SRC2+1:`OMD_ST_SRC2] = SRC2_SEL_OUT;
                rdata_d[`OMD_ST_SDS+1:`OMD_ST_SDS]   = SRCDST_SRC_SEL_OUT;
                rdata_d[`OMD_ST_SDD+1:`OMD_ST_SDD]   = SRCDST_DST_SEL_OUT;
                rdata_d[`OMD_ST_FMT+1:`OMD_ST_FMT]   = FORMAT_OUT;
                rdata_d[`OMD_ST_GUESS]               = GUESS_FALSE_OUT;
                rdata_d[`OMD_ST_FAULT]               = fault_seen_q;
            end
            `OMD_ADDR_FCNT: begin
                rdata_d[`OMD_FCNT_W-1:0] = fault_cnt_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PREADY_OUT  <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT  <= apb_access & ~PREADY_OUT;
            PSLVERR_OUT <= apb_access & ~PREADY_OUT & ~addr_ok;
            if (apb_access & ~PREADY_OUT & ~PWRITE_IN) begin
                PRDATA_OUT <= rdata_d;
            end else begin
                PRDATA_OUT <= 32'h0000_0000;
            end
        end
    end

    // Control, sticky fault flag and fault counter
    always @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ctrl_q       <= `OMD_CTRL_RESET;
            fault_seen_q <= 1'b0;
            fault_cnt_q  <= {`OMD_FCNT_W{1'b0}};
        end else begin
            if (apb_wr && PADDR_IN == `OMD_ADDR_CTRL) begin
                ctrl_q <= PWDATA_IN;
            end
            // New fault wins over a clear in the same cycle
            if (fault_evt) begin
                fault_seen_q <= 1'b1;
            end else if (apb_wr && PADDR_IN == `OMD_ADDR_STATUS &&
                         PWDATA_IN[`OMD_ST_FAULT]) begin
                fault_seen_q <= 1'b0;
            end
            if (fault_evt) begin
                fault_cnt_q <= fault_cnt_q + {{(`OMD_FCNT_W-1){1'b0}}, 1'b1};
            end else if (apb_wr && PADDR_IN == `OMD_ADDR_FCNT) begin
                fault_cnt_q <= {`OMD_FCNT_W{1'b0}};
            end
        end
    end
endmodule // omd_decoder

/* tb/omd_decoder_props.sv */
// Checker: decode outputs against the instruction word one cycle earlier.
// Assumes binding to omd_decoder; the fault enable register is not seen here.
`timescale 1ns/10ps
`include "omd_defines.vh"
module omd_decoder_props (
    input logic        CLK_IN,
    input logic        RESETN_IN,
    input logic [31:0] INSTR_IN,
    input logic        INSTR_VALID_IN,
    input logic        SRCDST_WRITTEN_IN,
    input logic [1:0]  SRC1_SEL_OUT,
    input logic [1:0]  SRC2_SEL_OUT,
    input logic [1:0]  SRCDST_SRC_SEL_OUT,
    input logic [1:0]  SRCDST_DST_SEL_OUT,
    input logic        HAS_GUESS_OUT,
    input logic        GUESS_FALSE_OUT,
    input logic        INVALID_OPCODE_OUT
);
    default clocking dclk @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    function automatic [1:0] sel2(input logic m, input logic s);
        sel2 = (m & s) ? 2'h3 : m ? 2'h1 : s ? 2'h2 : 2'h0;
    endfunction
    wire       reg_f = INSTR_IN[31:24] >= `OMD_REG_OPC_LO && !INSTR_IN[31];
    wire       cb_f  = INSTR_IN[31:29] == 3'b001;
    wire [1:0] e1    = sel2(INSTR_IN[11], INSTR_IN[5]);
    wire [1:0] e2    = sel2(INSTR_IN[12], INSTR_IN[6]);
    wire       bad_w = reg_f && (e1 == 2'h3 || e2 == 2'h3 || INSTR_IN[13] && SRCDST_WRITTEN_IN);
    sequence reg_s; INSTR_VALID_IN && reg_f; endsequence
    sequence cbr_s; INSTR_VALID_IN && cb_f; endsequence
    src1_sel_a: assert property (reg_s |=> SRC1_SEL_OUT == $past(e1))
        else $error("first source select wrong");
    src2_sel_a: assert property (reg_s |=> SRC2_SEL_OUT == $past(e2))
        else $error("second source select wrong");
    srcdst_sel_a: assert property (reg_s ##0 !SRCDST_WRITTEN_IN |=>
        {SRCDST_SRC_SEL_OUT, SRCDST_DST_SEL_OUT} == ($past(INSTR_IN[13]) ? 4'h6 : 4'h0))
        else $error("src/dst select wrong");
    cb_regs_a: assert property (cbr_s ##0 (!INSTR_IN[13] && !INSTR_IN[0]) |=>
        SRC1_SEL_OUT == 2'h0 && SRC2_SEL_OUT == 2'h0 && SRCDST_DST_SEL_OUT == 2'h0)
        else $error("compare-branch register row wrong");
    cb_lit_a: assert property (cbr_s ##0 (INSTR_IN[13] && !INSTR_IN[0]) |=>
        SRC1_SEL_OUT == 2'h1 && SRC2_SEL_OUT == 2'h0 && SRCDST_DST_SEL_OUT == 2'h0)
        else $error("compare-branch literal row wrong");
    cb_sfr_a: assert property (cbr_s ##0 INSTR_IN[0] |=> SRC2_SEL_OUT == 2'h2 &&
        SRCDST_DST_SEL_OUT == 2'h2 && SRC1_SEL_OUT == {1'b0, $past(INSTR_IN[13])})
        else $error("compare-branch special row wrong");
    guess_flag_a: assert property (INSTR_VALID_IN && INSTR_IN[31:30] == 2'b00 |=>
        HAS_GUESS_OUT && GUESS_FALSE_OUT == $past(INSTR_IN[1]))
        else $error("guess flag wrong");
    fault_cause_a: assert property (INVALID_OPCODE_OUT |-> $past(INSTR_VALID_IN && bad_w))
        else $error("fault without reserved word");
endmodule // omd_decoder_props

/* tb/omd_fetch_model.sv */
// Fetch side model: one word per call, scrambled bus when idle.
// Assumes callers run in the decoder's clock domain.
`timescale 1ns/10ps
module omd_fetch_model (
    input  wire        clk_in,
    output reg  [31:0] instr_out,
    output reg         valid_out,
    output reg         written_out
);
    initial begin
        instr_out   = 32'h0;
        valid_out   = 1'b0;
        written_out = 1'b0;
    end
    task send(input [31:0] w, input wr);
        begin
            @(posedge clk_in);
            instr_out   <= w;
            valid_out   <= 1'b1;
            written_out <= wr;
        end
    endtask
    task idle;
        begin
            @(posedge clk_in);
            instr_out   <= ~instr_out;
            valid_out   <= 1'b0;
            written_out <= ~written_out;
        end
    endtask
endmodule // omd_fetch_model

/* tb/operand_mode_decoder_tb_top.sv */
// Testbench top: decode table, back-to-back faults, fault enable, APB registers.
// Assumes omd_decoder, the fetch model and the checker are compiled first.
`timescale 1ns/10ps
`include "omd_defines.vh"
module operand_mode_decoder_tb_top;
    logic        CLK_IN, RESETN_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, INSTR_VALID_IN;
    logic        SRCDST_WRITTEN_IN, PREADY_OUT, PSLVERR_OUT, DEC_VALID_OUT, er, fen;
    logic        HAS_GUESS_OUT, GUESS_FALSE_OUT, INVALID_OPCODE_OUT;
    logic [11:0] PADDR_IN;
    logic [31:0] PWDATA_IN, PRDATA_OUT, INSTR_IN, rd;
    logic [1:0]  FORMAT_OUT, SRC1_SEL_OUT, SRC2_SEL_OUT, SRCDST_SRC_SEL_OUT, SRCDST_DST_SEL_OUT;
    int          fails, checks_done, i;
    logic [31:0] wv [15] = '{32'h58000000, 32'h58000800, 32'h58000020, 32'h58000820,
        32'h58001000, 32'h58000040, 32'h58001040, 32'h58002000, 32'h58002000, 32'h7f000000,
        32'h57000000, 32'h20002000, 32'h20000001, 32'h3f002003, 32'h00000002};
    logic [14:0] wrv = 15'h0101;
    omd_fetch_model u_fetch (.clk_in(CLK_IN), .instr_out(INSTR_IN), .valid_out(INSTR_VALID_IN),
        .written_out(SRCDST_WRITTEN_IN));
    omd_decoder u_dut (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .INSTR_IN(INSTR_IN),
        .INSTR_VALID_IN(INSTR_VALID_IN), .SRCDST_WRITTEN_IN(SRCDST_WRITTEN_IN),
        .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
        .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
        .PSLVERR_OUT(PSLVERR_OUT), .DEC_VALID_OUT(DEC_VALID_OUT), .FORMAT_OUT(FORMAT_OUT),
        .SRC1_SEL_OUT(SRC1_SEL_OUT), .SRC2_SEL_OUT(SRC2_SEL_OUT),
        .SRCDST_SRC_SEL_OUT(SRCDST_SRC_SEL_OUT), .SRCDST_DST_SEL_OUT(SRCDST_DST_SEL_OUT),
        .HAS_GUESS_OUT(HAS_GUESS_OUT), .GUESS_FALSE_OUT(GUESS_FALSE_OUT),
        .INVALID_OPCODE_OUT(INVALID_OPCODE_OUT));
    function automatic [1:0] s2(input logic m, input logic s);
        s2 = m ? (s ? 2'h3 : 2'h1) : (s ? 2'h2 : 2'h0);
    endfunction
    function automatic [12:0] expd(input [31:0] w, input wr);
        logic [1:0] f, a, b, c, d;
        logic       v;
        begin
            f = 2'h0;
            {a, b, c, d} = 8'hff;
            v = 1'b0;
            if (w[31:29] == 3'b000) f = 2'h3;
            else if (w[31:29] == 3'b001) begin
                f = 2'h2;
                a = {1'b0, w[13]};
                b = {w[0], 1'b0};
                d = b;
            end else if (w[31:24] >= 8'h58 && !w[31]) begin
                f = 2'h1;
                a = s2(w[11], w[5]);
                b = s2(w[12], w[6]);
                c = {1'b0, w[13]};
                d = {w[13], 1'b0};
                v = fen & (a == 2'h3 | b == 2'h3 | w[13] & wr);
            end
            expd = {f, a, b, c, d, f[1], f[1] & w[1], v};
        end
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        begin
            checks_done++;
            if (g !== e) begin
                fails++;
                $display("unexpected at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task dec(input [31:0] w, input wr);
        begin
            u_fetch.send(w, wr);
            u_fetch.idle;
            #1;
            chk({DEC_VALID_OUT, FORMAT_OUT, SRC1_SEL_OUT, SRC2_SEL_OUT, SRCDST_SRC_SEL_OUT,
                SRCDST_DST_SEL_OUT, HAS_GUESS_OUT, GUESS_FALSE_OUT, INVALID_OPCODE_OUT},
                {1'b1, expd(w, wr)});
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        int n;
        begin
            @(posedge CLK_IN);
            PSEL_IN <= 1'b1;
            PWRITE_IN <= w;
            PADDR_IN <= a;
            PWDATA_IN <= d;
            @(posedge CLK_IN);
            PENABLE_IN <= 1'b1;
            n = 0;
            do begin
                @(posedge CLK_IN);
                n++;
            end while (PREADY_OUT !== 1'b1 && n < 50);
            rd = PRDATA_OUT;
            er = PSLVERR_OUT;
            if (n >= 50) fails++;
            PSEL_IN <= 1'b0;
            PENABLE_IN <= 1'b0;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d fails %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        CLK_IN = 1'b0;
        forever #4 CLK_IN = ~CLK_IN;
    end
    initial begin
        repeat (4000) @(posedge CLK_IN);
        fails++;
        stop_test;
    end
    initial begin
        {RESETN_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN} = '0;
        {fails, checks_done, fen} = '0;
        fen = 1'b1;
        repeat (20) @(posedge CLK_IN);
        RESETN_IN <= 1'b1;
        apb(1'b0, `OMD_ADDR_CTRL, 32'h0);
        chk(rd, `OMD_CTRL_RESET);
        for (i = 0; i < 15; i++) dec(wv[i], wrv[i]);
        u_fetch.send(32'h58000820, 1'b0);
        dec(32'h58001040, 1'b0);
        apb(1'b0, `OMD_ADDR_FCNT, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, `OMD_ADDR_STATUS, 32'h0);
        chk(rd, 32'h90c);
        apb(1'b1, `OMD_ADDR_STATUS, 32'h800);
        apb(1'b1, `OMD_ADDR_FCNT, 32'h0);
        apb(1'b1, `OMD_ADDR_CTRL, 32'h0);
        fen = 1'b0;
        apb(1'b0, `OMD_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h0);
        dec(32'h58000820, 1'b0);
        apb(1'b0, `OMD_ADDR_STATUS, 32'h0);
        chk(rd, 32'h103);
        apb(1'b0, `OMD_ADDR_FCNT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h00c, 32'h1);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        stop_test;
    end
endmodule // operand_mode_decoder_tb_top
bind omd_decoder omd_decoder_props u_props (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
    .INSTR_IN(INSTR_IN), .INSTR_VALID_IN(INSTR_VALID_IN), .SRCDST_WRITTEN_IN(SRCDST_WRITTEN_IN),
    .SRC1_SEL_OUT(SRC1_SEL_OUT), .SRC2_SEL_OUT(SRC2_SEL_OUT),
    .SRCDST_SRC_SEL_OUT(SRCDST_SRC_SEL_OUT), .SRCDST_DST_SEL_OUT(SRCDST_DST_SEL_OUT),
    .HAS_GUESS_OUT(HAS_GUESS_OUT), .GUESS_FALSE_OUT(GUESS_FALSE_OUT),
    .INVALID_OPCODE_OUT(INVALID_OPCODE_OUT));
